// *** hdl/icoc_defs.vh ***
// offsets, field positions, reset values and counts of the input clock control block
`ifndef ICOC_DEFS_VH
`define ICOC_DEFS_VH

// ********************************
// register byte offsets
// ********************************
`define ICOC_OFS_CLK_MODE 8'h00
`define ICOC_OFS_PLL_CSR 8'h04
`define ICOC_OFS_PLL_MUL 8'h08
`define ICOC_OFS_PLL_DIV 8'h0C
`define ICOC_OFS_GRP_DIV 8'h10
`define ICOC_OFS_IDLE_STAT 8'h14

// ********************************
// field positions
// ********************************
`define ICOC_MODE_SEL 0
`define ICOC_CSR_PLL_ENABLE_BIT 0
`define ICOC_CSR_PWRDN 1
`define ICOC_CSR_OSC_ON 2
`define ICOC_CSR_STAB_BUSY 3
`define ICOC_CSR_FLOW 4
`define ICOC_IDLE_CLOCK_GENERATOR_IDLE_STATUS_BIT 0

// ********************************
// reset values and encodings
// ********************************
`define ICOC_MUL_RST 4'h2
`define ICOC_MUL_MIN 4'h2
`define ICOC_DIV_RST 5'h00
`define ICOC_GRP_DIV1 2'h0
`define ICOC_GRP_DIV2 2'h1
`define ICOC_GRP_DIV4 2'h2
`define ICOC_GRP_RST 6'h2A

// ********************************
// timing counts
// ********************************
`define ICOC_STAB_CYCLES 41032
`define ICOC_STRAP_WAIT 2'h2

`endif

// *** hdl/icoc_gfmux.v ***
// glitch-free two-source clock selector on sampled clock levels
`timescale 1ns/1ps
`default_nettype none

module icoc_gfmux
(
    input wire pclk,
    input wire presetn,
    input wire src_a,
    input wire src_b,
    input wire sel,
    output reg clk_out_q
);

reg cur_q;
wire new_lvl;
wire cur_lvl;

assign new_lvl = sel ? src_b : src_a;
assign cur_lvl = cur_q ? src_b : src_a;

// ********************************
// source switch
// ********************************
// swap only while output and new source are both low, so no short pulse
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        cur_q <= 1'b0;
        clk_out_q <= 1'b0;
    end
    else if ((sel != cur_q) && !clk_out_q && !new_lvl)
    begin
        cur_q <= sel;
        clk_out_q <= 1'b0;
    end
    else
    begin
        clk_out_q <= cur_lvl;
    end
end

endmodule

`default_nettype wire

// *** hdl/icoc_top.v ***
// input clock selection, pll emulation, group dividers and oscillator control
`timescale 1ns/1ps
`default_nettype none
`include "icoc_defs.vh"

module icoc_top
#(
    parameter STAB_CYCLES = `ICOC_STAB_CYCLES
)
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire oscillator_output_clock,
    input wire external_clock_input_pin,
    input wire clock_source_strap_pin,
    input wire clock_generator_idle_status_bit,
    output reg crystal_drive_enable_q,
    output reg input_clock_select_bit_q,
    output reg core_clk_q,
    output wire [2:0] group_clk_q,
    output reg program_flow_enable_q
);

localparam [3:0] ST_STRAP = 4'b0001;
localparam [3:0] ST_STAB = 4'b0010;
localparam [3:0] ST_RUN = 4'b0100;
localparam [3:0] ST_PDN = 4'b1000;
localparam [15:0] STAB_LOAD = STAB_CYCLES[15:0];

// pin synchronisers
reg osc_s1_q;
reg osc_s2_q;
reg ext_s1_q;
reg ext_s2_q;
reg strap_s1_q;
reg strap_s2_q;
reg osc_prev_q;

// software registers
reg pll_enable_bit_q;
reg pwrdn_q;
reg [3:0] mul_q;
reg [4:0] div_q;
reg [5:0] grp_code_q;

// sequencing
reg [3:0] state_q;
reg [1:0] wait_q;
reg [15:0] stab_q;

// clock path
wire in_clk;
wire core_clk;
reg in_prev_q;
reg core_prev_q;
reg [6:0] credit_q;
reg [6:0] credit_d;
reg nco_q;

// bus decode
reg [31:0] rd_d;
reg hit_d;
wire setup;
wire wr_en;
wire in_rise;
wire core_rise;
wire osc_rise;
wire [5:0] d_fac;
wire tog;
wire stab_busy;

assign setup = psel & ~penable;
assign wr_en = psel & penable & pready & pwrite & hit_d;
assign in_rise = in_clk & ~in_prev_q;
assign core_rise = core_clk & ~core_prev_q;
assign osc_rise = osc_s2_q & ~osc_prev_q;
assign d_fac = {1'b0, div_q} + 6'h01;
assign tog = (credit_q >= {1'b0, d_fac});
assign stab_busy = (stab_q != 16'h0000);

// ********************************
// pin synchronisers
// ********************************
// the oscillator, external clock and strap pins pass two flops before any logic looks at them
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        osc_s1_q <= 1'b0;
        osc_s2_q <= 1'b0;
        ext_s1_q <= 1'b0;
        ext_s2_q <= 1'b0;
        strap_s1_q <= 1'b0;
        strap_s2_q <= 1'b0;
        osc_prev_q <= 1'b0;
    end
    else
    begin
        osc_s1_q <= oscillator_output_clock;
        osc_s2_q <= osc_s1_q;
        ext_s1_q <= external_clock_input_pin;
        ext_s2_q <= ext_s1_q;
        strap_s1_q <= clock_source_strap_pin;
        strap_s2_q <= strap_s1_q;
        osc_prev_q <= osc_s2_q;
    end
end

// ********************************
// apb read decode
// ********************************
always @*
begin
    rd_d = 32'h00000000;
    hit_d = 1'b1;
    case (paddr)
        `ICOC_OFS_CLK_MODE:
        begin
            rd_d[`ICOC_MODE_SEL] = input_clock_select_bit_q;
        end
        `ICOC_OFS_PLL_CSR:
        begin
            rd_d[`ICOC_CSR_PLL_ENABLE_BIT] = pll_enable_bit_q;
            rd_d[`ICOC_CSR_PWRDN] = pwrdn_q;
            rd_d[`ICOC_CSR_OSC_ON] = crystal_drive_enable_q;
            rd_d[`ICOC_CSR_STAB_BUSY] = stab_busy;
            rd_d[`ICOC_CSR_FLOW] = program_flow_enable_q;
        end
        `ICOC_OFS_PLL_MUL:
        begin
            rd_d[3:0] = mul_q;
        end
        `ICOC_OFS_PLL_DIV:
        begin
            rd_d[4:0] = div_q;
        end
        `ICOC_OFS_GRP_DIV:
        begin
            rd_d[5:0] = grp_code_q;
        end
        `ICOC_OFS_IDLE_STAT:
        begin
            rd_d[`ICOC_IDLE_CLOCK_GENERATOR_IDLE_STATUS_BIT] = clock_generator_idle_status_bit;
        end
        default:
        begin
            hit_d = 1'b0;
        end
    endcase
end

// ********************************
// apb handshake
// ********************************
// one wait-free access cycle: answer prepared during setup
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end
    else
    begin
        pready <= setup;
        pslverr <= setup & ~hit_d;
        if (setup)
        begin
            prdata <= pwrite ? 32'h00000000 : rd_d;
        end
    end
end

// ********************************
// software registers
// ********************************
// multiplier below two is raised to two; divider holds factor minus one
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pll_enable_bit_q <= 1'b0;
        pwrdn_q <= 1'b0;
        mul_q <= `ICOC_MUL_RST;
        div_q <= `ICOC_DIV_RST;
        grp_code_q <= `ICOC_GRP_RST;
    end
    else if (wr_en)
    begin
        case (paddr)
            `ICOC_OFS_PLL_CSR:
            begin
                pll_enable_bit_q <= pwdata[`ICOC_CSR_PLL_ENABLE_BIT];
                pwrdn_q <= pwdata[`ICOC_CSR_PWRDN];
            end
            `ICOC_OFS_PLL_MUL:
            begin
                mul_q <= (pwdata[3:0] < `ICOC_MUL_MIN) ? `ICOC_MUL_MIN : pwdata[3:0];
            end
            `ICOC_OFS_PLL_DIV:
            begin
                div_q <= pwdata[4:0];
            end
            `ICOC_OFS_GRP_DIV:
            begin
                // code three is not a ratio: treated as divide-by-four
                grp_code_q[1:0] <= (pwdata[1:0] == 2'h3) ? `ICOC_GRP_DIV4 : pwdata[1:0];
                grp_code_q[3:2] <= (pwdata[3:2] == 2'h3) ? `ICOC_GRP_DIV4 : pwdata[3:2];
                grp_code_q[5:4] <= (pwdata[5:4] == 2'h3) ? `ICOC_GRP_DIV4 : pwdata[5:4];
            end
            default:
            begin
                pll_enable_bit_q <= pll_enable_bit_q;
            end
        endcase
    end
end

// ********************************
// strap, stabilization and power-down sequencer
// ********************************
// strap is caught after release, once the synchroniser has filled
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        state_q <= ST_STRAP;
        wait_q <= 2'h0;
        stab_q <= 16'h0000;
        input_clock_select_bit_q <= 1'b0;
        crystal_drive_enable_q <= 1'b1;
        program_flow_enable_q <= 1'b0;
    end
    else
    begin
        // counter runs on reference clock edges only
        if (stab_busy && osc_rise)
        begin
            stab_q <= stab_q - 16'h0001;
        end
        case (state_q)
            ST_STRAP:
            begin
                if (wait_q != `ICOC_STRAP_WAIT)
                begin
                    wait_q <= wait_q + 2'h1;
                end
                else if (!strap_s2_q)
                begin
                    input_clock_select_bit_q <= 1'b0;
                    stab_q <= STAB_LOAD;
                    state_q <= ST_STAB;
                end
                else
                begin
                    input_clock_select_bit_q <= 1'b1;
                    program_flow_enable_q <= 1'b1;
                    state_q <= ST_RUN;
                end
            end
            ST_STAB:
            begin
                // flow held until the count reaches zero, no extra delay
                if (!stab_busy)
                begin
                    program_flow_enable_q <= 1'b1;
                    state_q <= ST_RUN;
                end
            end
            ST_RUN:
            begin
                if (wr_en && (paddr == `ICOC_OFS_CLK_MODE))
                begin
                    input_clock_select_bit_q <= pwdata[`ICOC_MODE_SEL];
                end
                if (pwrdn_q && input_clock_select_bit_q)
                begin
                    crystal_drive_enable_q <= 1'b0;
                    state_q <= ST_PDN;
                end
                else if (pwrdn_q && clock_generator_idle_status_bit)
                begin
                    crystal_drive_enable_q <= 1'b0;
                    program_flow_enable_q <= 1'b0;
                    state_q <= ST_PDN;
                end
            end
            ST_PDN:
            begin
                if (!pwrdn_q)
                begin
                    crystal_drive_enable_q <= 1'b1;
                    stab_q <= STAB_LOAD;
                    state_q <= input_clock_select_bit_q ? ST_RUN : ST_STAB;
                end
            end
            default:
            begin
                state_q <= ST_STRAP;
            end
        endcase
    end
end

// ********************************
// input and mode selection
// ********************************
icoc_gfmux u_in_mux
(
    .pclk(pclk),
    .presetn(presetn),
    .src_a(osc_s2_q),
    .src_b(ext_s2_q),
    .sel(input_clock_select_bit_q),
    .clk_out_q(in_clk)
);

icoc_gfmux u_mode_mux
(
    .pclk(pclk),
    .presetn(presetn),
    .src_a(in_clk),
    .src_b(nco_q),
    .sel(pll_enable_bit_q),
    .clk_out_q(core_clk)
);

// ********************************
// pll rate emulation
// ********************************
// credit of 2*mul per input rise, each half period spends the divide factor;
// output rate limited to half of pclk, a trade for staying single-clock
always @*
begin
    credit_d = credit_q;
    // credit added only below half scale, so a product above pclk/2 cannot wrap it
    if (in_rise && !credit_q[6])
    begin
        credit_d = credit_d + {2'b00, mul_q, 1'b0};
    end
    if (tog)
    begin
        credit_d = credit_d - {1'b0, d_fac};
    end
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        in_prev_q <= 1'b0;
        core_prev_q <= 1'b0;
        credit_q <= 7'h00;
        nco_q <= 1'b0;
        core_clk_q <= 1'b0;
    end
    else
    begin
        in_prev_q <= in_clk;
        core_prev_q <= core_clk;
        credit_q <= credit_d;
        if (tog)
        begin
            nco_q <= ~nco_q;
        end
        core_clk_q <= core_clk;
    end
end

// ********************************
// clock group dividers
// ********************************
genvar g;
generate
    for (g = 0; g < 3; g = g + 1)
    begin : grp
        reg [1:0] code_q;
        reg [1:0] cnt_q;
        reg gclk_q;
        wire [1:0] want;
        assign want = grp_code_q[2 * g + 1:2 * g];
        assign group_clk_q[g] = gclk_q;
        // ratio changes only while both clocks are low
        always @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                code_q <= `ICOC_GRP_DIV4;
                cnt_q <= 2'h0;
                gclk_q <= 1'b0;
            end
            else if ((code_q != want) && !gclk_q && !core_clk)
            begin
                code_q <= want;
                cnt_q <= 2'h0;
            end
            else
            begin
                if (core_rise)
                begin
                    cnt_q <= cnt_q + 2'h1;
                end
                if (code_q == `ICOC_GRP_DIV1)
                begin
                    gclk_q <= core_clk;
                end
                else if (core_rise && ((code_q == `ICOC_GRP_DIV2) || cnt_q[0]))
                begin
                    gclk_q <= ~gclk_q;
                end
            end
        end
    end
endgenerate

endmodule

`default_nettype wire

// *** tb/icoc_checker.sv ***
// concurrent checks on the ports of the input clock control block
`timescale 1ns/1ps
`default_nettype none
module icoc_checker
#(
    parameter STAB_CYCLES = 41032
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic clock_generator_idle_status_bit,
    input wire logic crystal_drive_enable_q,
    input wire logic input_clock_select_bit_q,
    input wire logic program_flow_enable_q
);
    // ********************************
    // helpers and assertions
    // ********************************
    logic [31:0] wait_q;
    logic pd_wr;
    // power-down write in the access cycle
    assign pd_wr = psel && penable && pwrite && (paddr == 8'h04) && pwdata[1];
    // cycles spent waiting for the oscillator; budget assumes a slow clock under 16 pclk
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wait_q <= 32'h0;
        else if (program_flow_enable_q || input_clock_select_bit_q || !crystal_drive_enable_q)
            wait_q <= 32'h0;
        else
            wait_q <= wait_q + 32'h1;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_hold;
        !program_flow_enable_q [*8];
    endsequence
    AST_PREADY: assert property (s_setup |=> pready)
        else $error("access cycle without pready");
    AST_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_RDERR: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    AST_OSC_EXT: assert property (pd_wr && input_clock_select_bit_q |-> ##[1:2] !crystal_drive_enable_q)
        else $error("oscillator not stopped with external source");
    AST_OSC_IDLE: assert property ($fell(crystal_drive_enable_q) && !input_clock_select_bit_q
        |-> $past(clock_generator_idle_status_bit) || clock_generator_idle_status_bit)
        else $error("oscillator stopped without idle");
    AST_FLOW_OFF: assert property (!crystal_drive_enable_q && !input_clock_select_bit_q
        |=> !program_flow_enable_q)
        else $error("flow runs with oscillator off");
    AST_WAKE: assert property ($rose(crystal_drive_enable_q) && !input_clock_select_bit_q
        |=> s_hold)
        else $error("flow resumed before stabilisation");
    AST_FLOW_EXT: assert property ($rose(input_clock_select_bit_q) && !$past(program_flow_enable_q)
        |-> program_flow_enable_q)
        else $error("external boot waited for oscillator");
    AST_STAB: assert property (wait_q < (STAB_CYCLES * 16 + 64))
        else $error("stabilisation wait too long");
endmodule
`default_nettype wire

// *** tb/icoc_xtal_model.sv ***
// crystal oscillator and external clock source model
`timescale 1ns/1ps
`default_nettype none
module icoc_xtal_model
#(
    parameter real OSC_HALF = 101.3,
    parameter real EXT_HALF = 83.7
)
(
    input wire logic osc_enable,
    output logic osc_clk,
    output logic ext_clk
);
    // ********************************
    // sources
    // ********************************
    initial
    begin
        osc_clk = 1'b0;
        ext_clk = 1'b0;
    end
    // crystal swings only while driven; a stopped oscillator rests low
    always
    begin
        #OSC_HALF;
        osc_clk = osc_enable ? ~osc_clk : 1'b0;
    end
    // external clock free runs, half periods off the pclk grid
    always #EXT_HALF ext_clk = ~ext_clk;
endmodule
`default_nettype wire

// *** tb/icoc_top_test.sv ***
// self-checking testbench of the input clock control block
`timescale 1ns/1ps
`default_nettype none
module icoc_top_test;
    // ********************************
    // signals and instances
    // ********************************
    localparam STAB = 8;
    logic pclk, presetn, psel, penable, pwrite, idle, strap, osc, ext, pready, pslverr;
    logic xtal_en, sel_q, core, flow;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] grp;
    logic er;
    int n_fail, compares, cyc, c, g0, g1, g2;
    icoc_top #(.STAB_CYCLES(STAB)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .oscillator_output_clock(osc),
        .external_clock_input_pin(ext), .clock_source_strap_pin(strap),
        .clock_generator_idle_status_bit(idle), .crystal_drive_enable_q(xtal_en),
        .input_clock_select_bit_q(sel_q), .core_clk_q(core), .group_clk_q(grp),
        .program_flow_enable_q(flow));
    icoc_xtal_model u_xtal (.osc_enable(xtal_en), .osc_clk(osc), .ext_clk(ext));
    // clock, time-zero inputs and hang guard
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial
    begin
        {presetn, psel, penable, pwrite, idle, strap} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            n_fail++;
            stop_test;
        end
    end
    // ********************************
    // shared tasks
    // ********************************
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function logic near(input int a, input int b, input int t);
        return (a <= b + t) && (b <= a + t);
    endfunction
    // one apb transfer; holds the request until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge pclk);
        end
        chk("pready", pready, 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask
    task reset_dut(input logic s);
        presetn <= 1'b0;
        strap <= s;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task wait_flow(output int n);
        n = 0;
        while (flow !== 1'b1 && n < 3000)
        begin
            @(posedge pclk);
            n++;
        end
    endtask
    // rising edges of core and group clocks over 400 cycles
    task count_rises;
        logic [3:0] p;
        {c, g0, g1, g2} = 0;
        p = {core, grp};
        repeat (400)
        begin
            @(posedge pclk);
            c += int'(core & !p[3]);
            g2 += int'(grp[2] & !p[2]);
            g1 += int'(grp[1] & !p[1]);
            g0 += int'(grp[0] & !p[0]);
            p = {core, grp};
        end
    endtask
    // ********************************
    // scenarios
    // ********************************
    task t_osc_boot;
        int n;
        reset_dut(1'b0);
        repeat (6) @(posedge pclk);
        chk("select", sel_q, 0);
        chk("flow early", flow, 0);
        wait_flow(n);
        chk("flow", flow, 1);
        chk("stab length", n >= STAB * 5, 1);
        rdc(8'h00, 0, "mode rst");
        rdc(8'h04, 32'h14, "csr rst");
        rdc(8'h10, 32'h2A, "grp rst");
        rdc(8'h08, 2, "mul rst");
        $display("test osc_boot done");
    endtask
    task t_regs;
        apb(1'b1, 8'h08, 1);
        rdc(8'h08, 2, "mul min");
        apb(1'b1, 8'h08, 32'hF);
        rdc(8'h08, 32'hF, "mul max");
        apb(1'b1, 8'h0C, 32'h1F);
        rdc(8'h0C, 32'h1F, "div max");
        apb(1'b1, 8'h10, 32'h3F);
        rdc(8'h10, 32'h2A, "grp clamp");
        apb(1'b1, 8'h00, 1);
        rdc(8'h00, 1, "select sw");
        apb(1'b1, 8'h00, 0);
        rdc(8'h00, 0, "select back");
        idle <= 1'b1;
        rdc(8'h14, 1, "idle flag");
        idle <= 1'b0;
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped err", er, 1);
        chk("unmapped data", rd, 0);
        $display("test regs done");
    endtask
    task t_groups;
        int cb;
        apb(1'b1, 8'h10, 32'h24);
        repeat (40) @(posedge pclk);
        count_rises;
        cb = c;
        chk("grp fast", near(g0, cb, 3), 1);
        chk("grp slow", near(g1 * 2, cb, 4), 1);
        chk("grp emif", near(g2 * 4, cb, 5), 1);
        apb(1'b1, 8'h08, 3);
        apb(1'b1, 8'h0C, 0);
        apb(1'b1, 8'h04, 1);
        repeat (40) @(posedge pclk);
        count_rises;
        chk("pll x3", near(c, cb * 3, 6), 1);
        apb(1'b1, 8'h0C, 1);
        repeat (40) @(posedge pclk);
        count_rises;
        chk("pll x3/2", near(c * 2, cb * 3, 7), 1);
        apb(1'b1, 8'h04, 0);
        repeat (40) @(posedge pclk);
        count_rises;
        chk("bypass", near(c, cb, 3), 1);
        $display("test groups done");
    endtask
    task t_pwrdn;
        int n;
        idle <= 1'b0;
        apb(1'b1, 8'h04, 2);
        repeat (20) @(posedge pclk);
        chk("osc held", xtal_en, 1);
        idle <= 1'b1;
        n = 0;
        while (xtal_en !== 1'b0 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        chk("osc off", xtal_en, 0);
        chk("flow off", flow, 0);
        idle <= 1'b0;
        apb(1'b1, 8'h04, 0);
        repeat (2) @(posedge pclk);
        chk("osc on", xtal_en, 1);
        chk("flow held", flow, 0);
        wait_flow(n);
        chk("flow back", flow, 1);
        $display("test pwrdn done");
    endtask
    task t_ext_boot;
        reset_dut(1'b1);
        repeat (8) @(posedge pclk);
        chk("select ext", sel_q, 1);
        chk("flow ext", flow, 1);
        apb(1'b1, 8'h04, 2);
        repeat (2) @(posedge pclk);
        chk("osc off ext", xtal_en, 0);
        chk("flow kept", flow, 1);
        count_rises;
        chk("ext source", near(c, 60, 6), 1);
        $display("test ext_boot done");
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // main sequence
    initial
    begin
        t_osc_boot;
        t_regs;
        t_groups;
        t_pwrdn;
        t_ext_boot;
        stop_test;
    end
endmodule
bind icoc_top icoc_checker #(.STAB_CYCLES(STAB_CYCLES)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clock_generator_idle_status_bit(clock_generator_idle_status_bit),
    .crystal_drive_enable_q(crystal_drive_enable_q),
    .input_clock_select_bit_q(input_clock_select_bit_q),
    .program_flow_enable_q(program_flow_enable_q));
`default_nettype wire
